/* tb/ocs_osc_model.sv */
/*
 Crystal and internal oscillator model for the clock select bench.
 Assumes the block's enables gate the internal oscillators.
*/
`timescale 1ns/1ns
module ocs_osc_model (
	input wire logic fast_osc_en, // Fast osc enable
	input wire logic slow_osc_en, // Slow osc enable
	output logic crystal_in_pin, // Crystal, 48 ns period
	output logic secondary_crystal_in, // Scaled secondary crystal
	output logic fast_osc_clk, // Fast osc, 16 MHz
	output logic slow_osc_clk, // Scaled slow osc
	output logic startup_osc_clk, // Start-up osc
	output logic fast_osc_settled // Settle flag
);
	assign startup_osc_clk = fast_osc_clk;
	initial begin
		crystal_in_pin = 1'b0;
		secondary_crystal_in = 1'b0;
		fast_osc_settled = 1'b0;
		fork
			forever #24 crystal_in_pin = ~crystal_in_pin;
			forever #1500 secondary_crystal_in = ~secondary_crystal_in;
		join
	end
	// A stopped oscillator stands low; the slow rate is scaled to keep the run short
	always begin
		if (fast_osc_en === 1'b1) begin
			#31 fast_osc_clk = ~fast_osc_clk;
		end else begin
			fast_osc_clk = 1'b0;
			@(fast_osc_en);
		end
	end
	always begin
		if (slow_osc_en === 1'b1) begin
			#1000 slow_osc_clk = ~slow_osc_clk;
		end else begin
			slow_osc_clk = 1'b0;
			@(slow_osc_en);
		end
	end
	always @(posedge fast_osc_en) begin
		#1000 fast_osc_settled = fast_osc_en;
	end
	always @(negedge fast_osc_en) fast_osc_settled = 1'b0;
endmodule // ocs_osc_model

/* tb/tb_top.sv */
/*
 Self-checking bench for the oscillator clock select block.
 Assumes the oscillator model drives all oscillator inputs.
*/
`timescale 1ns/1ns
module tb_top;
	import ocs_pkg::*;
	localparam logic [23:0] CORNER = 24'hfe0197;
	logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready, clock_out_enable, clock_fail_monitor_en;
	logic two_speed_en, power_up_delay_done, wake_from_sleep, slow_peripheral_en, crystal_in_pin;
	logic secondary_crystal_in, fast_osc_clk, slow_osc_clk, startup_osc_clk, fast_osc_settled;
	logic fast_osc_en, slow_osc_en, sys_clk, cpu_hold, slow_timer_clk;
	logic crystal_out_pin_o, crystal_out_pin_oe, clock_in_pin_is_io;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rv, seed;
	logic [3:0] s_wstrb, code, prev;
	logic [2:0] default_oscillator_config;
	logic [1:0] s_bresp, s_rresp, rr;
	int n_mismatch, cmp_count, t;
	time t0;
	ocs_top ocs_top_inst (.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready,
		.s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr,
		.s_rvalid, .s_rready, .s_rdata, .s_rresp, .default_oscillator_config, .clock_out_enable,
		.clock_fail_monitor_en, .two_speed_en, .power_up_delay_done, .wake_from_sleep,
		.slow_peripheral_en, .crystal_in_pin, .secondary_crystal_in, .fast_osc_clk, .slow_osc_clk,
		.startup_osc_clk, .fast_osc_settled, .fast_osc_en, .slow_osc_en, .sys_clk, .cpu_hold,
		.slow_timer_clk, .crystal_out_pin_o, .crystal_out_pin_oe, .clock_in_pin_is_io);
	ocs_osc_model ocs_osc_model_inst (.fast_osc_en, .slow_osc_en, .crystal_in_pin,
		.secondary_crystal_in, .fast_osc_clk, .slow_osc_clk, .startup_osc_clk, .fast_osc_settled);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic give_verdict;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tmo;
		chk(32'h0, 32'h1);
		give_verdict;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_awvalid <= 1'b1;
		s_awaddr <= a;
		s_wvalid <= 1'b1;
		s_wdata <= d;
		s_wstrb <= 4'hf;
		s_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_awvalid && s_awready) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready) s_wvalid <= 1'b0;
		end while (!(s_bvalid && s_bready) && n < 100);
		if (n >= 100) tmo;
		rr = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		int n;
		@(posedge aclk);
		s_arvalid <= 1'b1;
		s_araddr <= a;
		s_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_arvalid && s_arready) s_arvalid <= 1'b0;
		end while (!(s_rvalid && s_rready) && n < 100);
		if (n >= 100) tmo;
		rv = s_rdata;
		rr = s_rresp;
		s_rready <= 1'b0;
	endtask
	task automatic hold_wait(input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (cpu_hold !== v && n < lim);
		if (n >= lim) tmo;
	endtask
	// Hold must last through 1010 crystal periods of 6 cycles, then drop
	task automatic ost_run;
		repeat (6060) begin
			@(posedge aclk);
			chk(cpu_hold, 1'b1);
		end
		hold_wait(1'b0, 600);
	endtask
	task automatic wake;
		wake_from_sleep <= 1'b1;
		@(posedge aclk);
		wake_from_sleep <= 1'b0;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic fst(input logic [3:0] c);
		return c >= 4'h2;
	endfunction
	initial begin
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, wake_from_sleep} = '0;
		{s_awaddr, s_wdata, s_araddr, s_wstrb} = '0;
		{clock_out_enable, clock_fail_monitor_en, two_speed_en, power_up_delay_done, slow_peripheral_en} = '0;
		default_oscillator_config = OCS_FOSC_XT;
		n_mismatch = 0;
		cmp_count = 0;
		seed = 32'h094795cf;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(32'(OCS_ADDR_CTRL));
		chk(rv, 32'h7);
		repeat (100) @(posedge aclk);
		chk(cpu_hold, 1'b1);
		power_up_delay_done <= 1'b1;
		ost_run;
		rd(32'(OCS_ADDR_STAT));
		chk(rv[3], 1'b1);
		wake;
		hold_wait(1'b1, 10);
		ost_run;
		two_speed_en <= 1'b1;
		wake;
		repeat (5) @(posedge aclk);
		chk(cpu_hold, 1'b0);
		rd(32'(OCS_ADDR_STAT));
		chk(rv[3], 1'b0);
		rd(32'hc);
		chk(rv, 32'h0);
		chk(rr, OCS_RESP_SLVERR);
		wr(32'h10, 32'h0);
		chk(rr, OCS_RESP_SLVERR);
		$display("Test start-up and bus done");
		prev = OCS_IRCF_RESET;
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			code = (i < 6) ? CORNER[23 - 4 * i -: 4] : seed[3:0];
			wr(32'(OCS_ADDR_CTRL), {26'h0, OCS_SEL_INTERNAL, code});
			t0 = $time;
			rv = '0;
			t = 0;
			while (!(rv[8] && rv[7:4] == code) && t < 2500) begin
				rd(32'(OCS_ADDR_STAT));
				t++;
			end
			if (t >= 2500) tmo;
			t = int'(($time - t0) / 8);
			chk(rv[2:0], {~fst(code), fst(code), fst(code)});
			chk({fast_osc_en, slow_osc_en}, {fst(code), ~fst(code)});
			if (i > 0 && fst(code) != fst(prev)) chk(t >= 250, 1'b1);
			if (i > 0 && prev >= 4'hb && code >= 4'hb) chk(t < 250, 1'b1);
			prev = code;
		end
		$display("Test switching done");
		wr(32'(OCS_ADDR_CTRL), 32'h2f);
		slow_peripheral_en <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(slow_osc_en, 1'b1);
		slow_peripheral_en <= 1'b0;
		default_oscillator_config <= OCS_FOSC_INT;
		wr(32'(OCS_ADDR_CTRL), 32'h0f);
		repeat (3) @(posedge aclk);
		chk(fast_osc_en, 1'b1);
		wr(32'(OCS_ADDR_CTRL), 32'h1f);
		rd(32'(OCS_ADDR_CTRL));
		chk(rv, 32'h1f);
		rv[0] = sys_clk;
		t = 0;
		repeat (400) begin
			@(posedge aclk);
			if (sys_clk !== rv[0]) t++;
			rv[0] = sys_clk;
		end
		chk(t >= 2, 1'b1);
		for (int m = 0; m < 4; m++) begin
			default_oscillator_config <= m[1] ? OCS_FOSC_INT : OCS_FOSC_RC;
			clock_out_enable <= m[0];
			repeat (3) @(posedge aclk);
			chk(crystal_out_pin_oe, m[0]);
			chk(clock_in_pin_is_io, m[1]);
			rd(32'(OCS_ADDR_CFG));
			chk(rv, {27'h0, m[0], 1'b0, default_oscillator_config});
		end
		$display("Test pins done");
		give_verdict;
	end
endmodule // tb_top

/* verilog/ocs_pkg.sv */
/*
 Constants, register map and state types for the oscillator clock select block.
 Assumes a single 125 MHz bus clock; oscillator and pin inputs arrive asynchronously.
*/
// Contract
// - Crystal modes count 1024 crystal input oscillations
// - Start-up count restarts at reset, power-up, wake
// - Execution held while counting unless monitor/two-speed
// - Secondary crystal selectable as runtime system clock
// - Internal mode frees clock input pin
// - clock_out_enable picks clock out or I/O
// - Fast 16 MHz and slow 31 kHz oscillators
// - Fast osc enabled by fast code and mode
// - fast_osc_ready when running, stable when settled
// - Slow osc enabled by code 000 or peripherals
// - Slow osc clocks timers; slow_osc_ready shown
// - Postscaler offers listed fast and slow frequencies
// - Reset loads frequency select with 0111
// - Duplicate slow-frequency codes allowed
// - Switch: start delay, wait edges, activate
// - Status updated after new clock active
// - Same-oscillator switch skips start-up delay; the code still warms up when the target oscillator is stopped
// - Start-up oscillator clocks before fast osc ready
// - Select default, secondary or internal clock
// - Select codes 00 default, 01 secondary, 1x internal
// - Reset clears system clock select
package ocs_pkg;
	localparam logic [3:0] OCS_ADDR_CTRL = 4'h0;
	localparam logic [3:0] OCS_ADDR_STAT = 4'h4;
	localparam logic [3:0] OCS_ADDR_CFG = 4'h8;
	localparam logic [3:0] OCS_IRCF_RESET = 4'h7;
	localparam logic [1:0] OCS_SCS_RESET = 2'h0;
	localparam logic [2:0] OCS_FOSC_LP = 3'h0;
	localparam logic [2:0] OCS_FOSC_XT = 3'h1;
	localparam logic [2:0] OCS_FOSC_HS = 3'h2;
	localparam logic [2:0] OCS_FOSC_RC = 3'h3;
	localparam logic [2:0] OCS_FOSC_INT = 3'h4;
	localparam logic [10:0] OCS_OST_COUNT = 11'h400;
	localparam int OCS_WARM_NS = 2000;
	localparam int OCS_CLK_NS = 8;
	localparam logic [8:0] OCS_WARM_CYC = 9'(OCS_WARM_NS / OCS_CLK_NS);
	localparam logic [1:0] OCS_SEL_DEFAULT = 2'h0;
	localparam logic [1:0] OCS_SEL_SECONDARY = 2'h1;
	localparam logic [1:0] OCS_SEL_INTERNAL = 2'h2;
	localparam logic [1:0] OCS_RESP_OKAY = 2'h0;
	localparam logic [1:0] OCS_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {OCS_IDLE, OCS_WARM, OCS_WAIT_FALL, OCS_WAIT_RISE, OCS_UPDATE} ocs_sw_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] araddr;
	} ocs_axi_req_t;
endpackage

/* verilog/ocs_top.sv */
/*
 Oscillator clock select: start-up timer, internal oscillator control,
 glitch-free internal frequency switch and system clock select, with an AXI4-Lite register slave.
 Assumes oscillators run asynchronously and are observed as sampled levels; the mux output is a sampled clock.
*/
`timescale 1ns/1ns
module ocs_top
	import ocs_pkg::*;
(
	input wire logic aclk, // Bus clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic s_awvalid, // Write address valid
	output logic s_awready, // Write address ready
	input wire logic [31:0] s_awaddr, // Write address
	input wire logic s_wvalid, // Write data valid
	output logic s_wready, // Write data ready
	input wire logic [31:0] s_wdata, // Write data
	input wire logic [3:0] s_wstrb, // Byte strobes
	output logic s_bvalid, // Write response valid
	input wire logic s_bready, // Write response ready
	output logic [1:0] s_bresp, // Write response
	input wire logic s_arvalid, // Read address valid
	output logic s_arready, // Read address ready
	input wire logic [31:0] s_araddr, // Read address
	output logic s_rvalid, // Read data valid
	input wire logic s_rready, // Read data ready
	output logic [31:0] s_rdata, // Read data
	output logic [1:0] s_rresp, // Read response
	input wire logic [2:0] default_oscillator_config, // Configuration word mode
	input wire logic clock_out_enable, // Configuration word
	input wire logic clock_fail_monitor_en, // Monitor enabled
	input wire logic two_speed_en, // Two-speed start-up enabled
	input wire logic power_up_delay_done, // Power-up delay timer expired
	input wire logic wake_from_sleep, // Wake-up pulse
	input wire logic slow_peripheral_en, // Timer that needs slow osc on
	input wire logic crystal_in_pin, // Crystal or external clock pin
	input wire logic secondary_crystal_in, // Secondary crystal oscillator
	input wire logic fast_osc_clk, // Fast oscillator output
	input wire logic slow_osc_clk, // Slow oscillator output
	input wire logic startup_osc_clk, // Fast start-up oscillator
	input wire logic fast_osc_settled, // Analog settle indication
	output logic fast_osc_en, // Fast oscillator enable
	output logic slow_osc_en, // Slow oscillator enable
	output logic sys_clk, // Selected system clock
	output logic cpu_hold, // Program counter hold
	output logic slow_timer_clk, // Clock for delay, watchdog, monitor
	output logic crystal_out_pin_o, // Crystal out pin value
	output logic crystal_out_pin_oe, // Crystal out pin is clock out
	output logic clock_in_pin_is_io // Clock input pin free for I/O
);
	typedef struct packed {
		logic [3:0] ircf;
		logic [1:0] scs;
		logic [3:0] active_ircf;
		logic [10:0] ost_cnt;
		logic ost_done;
		logic [8:0] warm_cnt;
		ocs_sw_t sw;
		logic hold_low;
		logic [5:0] s1, s2, s3;
		logic [15:0] div;
		logic [3:0] wstrb;
		logic fast_run, slow_run;
		logic aw_got, w_got, bvalid, rvalid;
		logic [31:0] awaddr, wdata, rdata;
		logic [1:0] bresp, rresp;
		logic sysclk;
	} ocs_state_t;
	ocs_state_t q, d;
	logic [5:0] raw;
	logic xtal_mode, internal_mode, new_fast, cur_clk, new_clk, wr_fire, ost_restart;
	logic int_clk, aw_page, ar_page;

	// Bit 5 is the fast oscillator itself; bit 3 only covers its start-up
	assign raw = {fast_osc_clk, fast_osc_settled, startup_osc_clk, slow_osc_clk, secondary_crystal_in, crystal_in_pin};
	assign xtal_mode = default_oscillator_config inside {OCS_FOSC_LP, OCS_FOSC_XT, OCS_FOSC_HS};
	assign internal_mode = default_oscillator_config == OCS_FOSC_INT;
	// Codes 0000 and 0001 both pick the slow oscillator; code 0010 the slowest fast divide
	function automatic logic is_fast(input logic [3:0] c);
		is_fast = c > 4'h1;
	endfunction
	assign new_fast = is_fast(q.ircf);
	assign ost_restart = wake_from_sleep || !power_up_delay_done;

	// Divide chain bit k gives 16 MHz / 2^(k+1)
	function automatic logic pick(input logic [3:0] c, input logic [15:0] dv, input logic fo, input logic so);
		// 1111=16M ... 1011=1M; 1010..1000 repeat 500k..125k; 0111=500k ... 0011/0010=31.25k; 0000/0001 slow
		if (c == 4'hf) pick = fo;
		else if (c >= 4'h8) pick = dv[4'he - c];
		else if (c >= 4'h3) pick = dv[4'hb - c];
		else if (c == 4'h2) pick = dv[4'h8];
		else pick = so;
	endfunction
	assign cur_clk = pick(q.active_ircf, q.div, q.s2[5], q.s2[2]);
	assign new_clk = pick(q.ircf, q.div, q.s2[5], q.s2[2]);
	// Upper address bits must be clear, so no register aliases above the map
	assign aw_page = q.awaddr[31:4] == '0;
	assign ar_page = s_araddr[31:4] == '0;
	// Start-up oscillator stands in until the fast oscillator reports ready
	assign int_clk = q.hold_low ? 1'b0 : (is_fast(q.active_ircf) && !q.fast_run) ? q.s2[3] : cur_clk;
	assign wr_fire = q.aw_got && q.w_got && !q.bvalid;

	always_comb begin
		d = q;
		// Two-stage sync of pins and oscillators; s3 is an edge history
		d.s1 = raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.fast_run = fast_osc_en;
		d.slow_run = slow_osc_en;
		if (q.s2[5] && !q.s3[5]) d.div = q.div + 16'h1;
		// Start-up timer counts crystal-pin rising edges
		if (ost_restart || !xtal_mode) begin
			d.ost_cnt = 11'h0;
			d.ost_done = !xtal_mode;
		end else if (!q.ost_done && q.s2[0] && !q.s3[0]) begin
			d.ost_cnt = q.ost_cnt + 11'h1;
			if (q.ost_cnt + 11'h1 == OCS_OST_COUNT) d.ost_done = 1'b1;
		end
		// Internal switch sequence
		case (q.sw)
			OCS_IDLE: begin
				if (q.ircf != q.active_ircf) begin
					// A stopped target oscillator needs the warm-up even on a same-source switch
					if (is_fast(q.ircf) == is_fast(q.active_ircf) && (is_fast(q.ircf) ? q.fast_run : q.slow_run))
						d.sw = OCS_WAIT_FALL;
					else begin
						d.sw = OCS_WARM;
						d.warm_cnt = OCS_WARM_CYC;
					end
				end
			end
			OCS_WARM: begin
				if (q.warm_cnt <= 9'h1) d.sw = OCS_WAIT_FALL;
				else d.warm_cnt = q.warm_cnt - 9'h1;
			end
			OCS_WAIT_FALL: begin
				if (!cur_clk) begin
					d.hold_low = 1'b1;
					d.sw = OCS_WAIT_RISE;
				end
			end
			OCS_WAIT_RISE: begin
				if (new_clk) begin
					d.hold_low = 1'b0;
					d.active_ircf = q.ircf;
					d.sw = OCS_UPDATE;
				end
			end
			OCS_UPDATE: d.sw = OCS_IDLE;
			default: d.sw = OCS_IDLE;
		endcase
		// System clock mux, registered
		if (q.scs[1]) d.sysclk = int_clk;
		else if (q.scs == OCS_SEL_SECONDARY) d.sysclk = q.s2[1];
		else if (internal_mode) d.sysclk = int_clk;
		else d.sysclk = q.ost_done ? q.s2[0] : 1'b0;
		// AXI4-Lite write
		if (s_awvalid && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.awaddr = s_awaddr;
		end
		if (s_wvalid && !q.w_got) begin
			d.w_got = 1'b1;
			d.wdata = s_wdata;
			d.wstrb = s_wstrb;
		end
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = OCS_RESP_OKAY;
			if (aw_page && q.awaddr[3:0] == OCS_ADDR_CTRL) begin
				if (q.wstrb[0]) begin
					d.ircf = q.wdata[3:0];
					d.scs = q.wdata[5:4];
				end
			end else if (aw_page && (q.awaddr[3:0] == OCS_ADDR_STAT || q.awaddr[3:0] == OCS_ADDR_CFG)) begin
				d.bresp = OCS_RESP_OKAY;
			end else d.bresp = OCS_RESP_SLVERR;
		end
		if (q.bvalid && s_bready) d.bvalid = 1'b0;
		// AXI4-Lite read
		if (s_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = OCS_RESP_OKAY;
			if (ar_page && s_araddr[3:0] == OCS_ADDR_CTRL) d.rdata = {26'h0, q.scs, q.ircf};
			else if (ar_page && s_araddr[3:0] == OCS_ADDR_STAT)
				d.rdata = {23'h0, q.sw == OCS_IDLE, q.active_ircf, q.ost_done, q.slow_run, q.s2[4] && q.fast_run, q.fast_run};
			else if (ar_page && s_araddr[3:0] == OCS_ADDR_CFG)
				d.rdata = {27'h0, clock_out_enable, 1'b0, default_oscillator_config};
			else begin
				d.rdata = 32'h0;
				d.rresp = OCS_RESP_SLVERR;
			end
		end
		if (q.rvalid && s_rready) d.rvalid = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.ircf <= OCS_IRCF_RESET;
			q.active_ircf <= OCS_IRCF_RESET;
			q.scs <= OCS_SCS_RESET;
			q.sw <= OCS_IDLE;
		end else begin
			q <= d;
		end
	end

	assign s_awready = !q.aw_got;
	assign s_wready = !q.w_got;
	assign s_bvalid = q.bvalid;
	assign s_bresp = q.bresp;
	assign s_arready = !q.rvalid;
	assign s_rvalid = q.rvalid;
	assign s_rdata = q.rdata;
	assign s_rresp = q.rresp;
	// Both the requested and the still-active selection keep their source alive during a switch
	assign fast_osc_en = (q.scs[1] || internal_mode) && (new_fast || is_fast(q.active_ircf));
	assign slow_osc_en = ((q.scs[1] || internal_mode) && (!new_fast || !is_fast(q.active_ircf)))
		|| slow_peripheral_en || clock_fail_monitor_en;
	assign slow_timer_clk = q.s2[2];
	assign sys_clk = q.sysclk;
	assign cpu_hold = !q.ost_done && !clock_fail_monitor_en && !two_speed_en;
	assign clock_in_pin_is_io = internal_mode;
	assign crystal_out_pin_oe = (internal_mode || default_oscillator_config == OCS_FOSC_RC) && clock_out_enable;
	assign crystal_out_pin_o = q.sysclk;

	property p_reset_ircf;
		@(posedge aclk) $rose(aresetn) |-> q.ircf == OCS_IRCF_RESET && q.scs == OCS_SCS_RESET;
	endproperty
	a_reset_ircf: assert property (p_reset_ircf) else $error("reset values wrong");

	property p_ost_done;
		@(posedge aclk) disable iff (!aresetn) xtal_mode && !ost_restart && $rose(q.ost_done) |-> q.ost_cnt == OCS_OST_COUNT;
	endproperty
	a_ost_done: assert property (p_ost_done) else $error("start-up timer count wrong");

	property p_hold;
		@(posedge aclk) disable iff (!aresetn) cpu_hold |-> !q.ost_done && !two_speed_en;
	endproperty
	a_hold: assert property (p_hold) else $error("hold wrong");

	property p_same_src;
		@(posedge aclk) disable iff (!aresetn) q.sw == OCS_IDLE && q.ircf != q.active_ircf
			&& is_fast(q.ircf) == is_fast(q.active_ircf)
			&& (is_fast(q.ircf) ? q.fast_run : q.slow_run) |=> q.sw == OCS_WAIT_FALL;
	endproperty
	a_same_src: assert property (p_same_src) else $error("needless warm-up");

	property p_warm;
		@(posedge aclk) disable iff (!aresetn) q.sw == OCS_IDLE && is_fast(q.ircf) != is_fast(q.active_ircf)
			|=> q.sw == OCS_WARM;
	endproperty
	a_warm: assert property (p_warm) else $error("missing warm-up");

	property p_low;
		@(posedge aclk) disable iff (!aresetn) q.sw == OCS_WAIT_RISE |-> int_clk == 1'b0;
	endproperty
	a_low: assert property (p_low) else $error("clock not held low");

	property p_update;
		@(posedge aclk) disable iff (!aresetn) q.sw == OCS_UPDATE |-> q.active_ircf == q.ircf ##1 q.sw == OCS_IDLE;
	endproperty
	a_update: assert property (p_update) else $error("switch did not complete");

	property p_fast_en;
		@(posedge aclk) disable iff (!aresetn) q.scs[1] && new_fast |-> fast_osc_en;
	endproperty
	a_fast_en: assert property (p_fast_en) else $error("fast oscillator off");

	property p_slow_en;
		@(posedge aclk) disable iff (!aresetn) slow_peripheral_en || (q.scs[1] && !new_fast) |-> slow_osc_en;
	endproperty
	a_slow_en: assert property (p_slow_en) else $error("slow oscillator off");

	property p_ircf_load;
		@(posedge aclk) !aresetn |=> q.ircf == OCS_IRCF_RESET;
	endproperty
	a_ircf_load: assert property (p_ircf_load) else $error("frequency select not reloaded");

	property p_scs_clear;
		@(posedge aclk) !aresetn |=> q.scs == OCS_SCS_RESET;
	endproperty
	a_scs_clear: assert property (p_scs_clear) else $error("clock select not cleared");

	property p_warm_len;
		@(posedge aclk) disable iff (!aresetn) q.sw == OCS_IDLE ##1 q.sw == OCS_WARM |-> q.warm_cnt == OCS_WARM_CYC;
	endproperty
	a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong");

	property p_ost_gate;
		@(posedge aclk) disable iff (!aresetn) xtal_mode && q.scs == OCS_SEL_DEFAULT && !q.ost_done |=> !q.sysclk;
	endproperty
	a_ost_gate: assert property (p_ost_gate) else $error("crystal clock used before count");

	property p_sec_sel;
		@(posedge aclk) disable iff (!aresetn) q.scs == OCS_SEL_SECONDARY |=> q.sysclk == $past(q.s2[1]);
	endproperty
	a_sec_sel: assert property (p_sec_sel) else $error("secondary clock not selected");

	property p_hold_sys;
		@(posedge aclk) disable iff (!aresetn) q.scs[1] && q.hold_low |=> !q.sysclk;
	endproperty
	a_hold_sys: assert property (p_hold_sys) else $error("system clock not held low");

	property p_fast_off;
		@(posedge aclk) disable iff (!aresetn) !q.scs[1] && !internal_mode |-> !fast_osc_en;
	endproperty
	a_fast_off: assert property (p_fast_off) else $error("fast oscillator left on");

	property p_clkout;
		@(posedge aclk) disable iff (!aresetn) crystal_out_pin_oe |-> clock_out_enable;
	endproperty
	a_clkout: assert property (p_clkout) else $error("clock out without enable");

	property p_rd_hold;
		@(posedge aclk) disable iff (!aresetn) s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");

	property p_wr_hold;
		@(posedge aclk) disable iff (!aresetn) s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
endmodule // ocs_top
